//--- design/ddr_irq_cfg.svh
// Offsets, field positions, reset values and fixed geometry of the irq/option block.
`ifndef DDR_IRQ_CFG_SVH
`define DDR_IRQ_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define OFS_FLAGS      8'h00
`define OFS_ACK        8'h04
`define OFS_MASK       8'h08
`define OFS_CTRL       8'h0c
`define OFS_GEOM       8'h10
`define OFS_BAD_ADDR   8'h14
`define OFS_BAD_INFO   8'h18

// ==========================================================================
// Flag bit positions
`define FLG_OOR_ONE    0
`define FLG_OOR_MANY   1
`define FLG_INIT_DONE  2
`define FLG_PAGE_CROSS 3
`define FLG_DLL_UNLOCK 4
`define FLG_ANY        5

// ==========================================================================
// Control bit positions
`define CTL_AP_BREAK   0
`define CTL_RD_BREAK   1
`define CTL_WR_BREAK   2
`define CTL_INIT_GATE  3

// ==========================================================================
// Geometry and bad-access info field positions
`define GEO_COL_LSB    0
`define GEO_ROW_LSB    4
`define GEO_CS_LSB     8
`define INF_LEN_LSB    0
`define INF_SRC_LSB    16
`define INF_KIND_LSB   20

// ==========================================================================
// Reset values and fixed capabilities
`define RST_MASK       6'h00
`define RST_CTRL       4'h0
`define GEO_MAX_COL    4'hc
`define GEO_MAX_ROW    4'he
`define GEO_MAX_CS     2'h2

`endif

//--- design/ddr_irq_pkg.sv
// Types shared by the irq/option block and its command gate.
package ddr_irq_pkg;

  typedef enum logic [2:0] {
    cmd_ref,
    cmd_pre,
    cmd_act,
    cmd_rd,
    cmd_wr,
    cmd_mrs
  } cmd_kind_e;

  typedef struct packed {
    logic [30:0] addr;
    logic [9:0]  len;
    logic [2:0]  src;
    logic [1:0]  kind;
  } bad_cmd_s;

  typedef struct packed {
    logic       active;
    logic       is_write;
    logic       autoprecharge;
    logic [2:0] bank;
  } open_op_s;

  typedef struct packed {
    logic       valid;
    cmd_kind_e  kind;
    logic [2:0] bank;
  } new_cmd_s;

endpackage : ddr_irq_pkg

//--- design/ddr_cmd_gate.sv
// Command gate applied while the DRAM DLL is initialising.
`timescale 1ns/1ps
module ddr_cmd_gate (
  input  wire logic               i_clk,
  input  wire logic               i_arst_n,
  input  wire logic               i_dll_init_busy,
  input  wire logic               i_gate_all,
  input  ddr_irq_pkg::new_cmd_s   i_cmd,
  output logic                    o_issue_q,
  output logic                    o_held_q
);

  logic is_ref_pre;
  logic allowed;

  // ========================================================================
  // Gating decision
  assign is_ref_pre = (i_cmd.kind == ddr_irq_pkg::cmd_ref) ||
                      (i_cmd.kind == ddr_irq_pkg::cmd_pre);

  assign allowed = !i_dll_init_busy || (!i_gate_all && is_ref_pre);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_issue_q <= 1'b0;
      o_held_q  <= 1'b0;
    end else begin
      o_issue_q <= i_cmd.valid && allowed;
      o_held_q  <= i_cmd.valid && !allowed;
    end
  end

  // ========================================================================
  // Checks
  property p_gate_none;
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_dll_init_busy && i_gate_all) |=> !o_issue_q;
  endproperty
  a_gate_none: assert property (p_gate_none) else $error("command issued while gated");

  property p_gate_refpre;
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_dll_init_busy && !i_gate_all && i_cmd.valid) |=> (o_issue_q == $past(is_ref_pre));
  endproperty
  a_gate_refpre: assert property (p_gate_refpre) else $error("ref/pre gating wrong");

endmodule : ddr_cmd_gate

//--- design/ddr_irq_ctrl.sv
// Interrupt flags, bad-access capture and command options of the DDR controller.
//
// What this block does
// - Interrupt equals flags AND inverted mask.
// - Flag bit 5 is OR of lower flags.
// - Flag 0 set on one out-of-range access.
// - Flag 1 set on repeated out-of-range accesses.
// - Flag 2 init done, flag 3 page cross.
// - Flag 4 set on DLL unlock.
// - Other-bank break allowed; original bank still precharged.
// - Read-AP breakable by same-bank read if enabled.
// - Write-AP breakable by same-bank read/write if enabled.
// - Read-only maximum column width, four bits.
// - Read-only maximum row width, four bits.
// - Chip-select limit as log2, two bits.
// - DLL init: only ref/pre, or nothing.
// - Capture out-of-range command address, 31 bits.
// - Capture out-of-range command length, ten bits.
// - Ack ones clear flags; ack reads zero.
// - Capture out-of-range source and command kind.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "ddr_irq_cfg.svh"
module ddr_irq_ctrl (
  input  wire logic               i_clk,
  input  wire logic               i_arst_n,
  // Register port
  input  wire logic [7:0]         i_addr,
  input  wire logic [31:0]        i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic [31:0]             o_rdata_q,
  // Events from the controller core
  input  wire logic               i_oor_valid,
  input  ddr_irq_pkg::bad_cmd_s   i_oor_cmd,
  input  wire logic               i_init_done,
  input  wire logic               i_page_cross,
  input  wire logic               i_dll_unlock,
  input  wire logic               i_dll_init_busy,
  // Command scheduling
  input  ddr_irq_pkg::open_op_s   i_open_op,
  input  ddr_irq_pkg::new_cmd_s   i_new_cmd,
  input  wire logic               i_owed_pre_done,
  output logic                    o_break_q,
  output logic                    o_owe_pre_q,
  output logic [2:0]              o_owe_bank_q,
  output logic                    o_issue_q,
  output logic                    o_held_q,
  output logic                    o_irq_q
);

  // ========================================================================
  // Register state
  logic [5:0]             flags_q;
  logic [4:0]             flags_d;
  logic [5:0]             mask_q;
  logic [3:0]             ctrl_q;
  ddr_irq_pkg::bad_cmd_s  bad_q;
  logic [4:0]             ack_bits;
  logic [4:0]             set_bits;
  logic                   ap_break_en;
  logic                   rd_break_en;
  logic                   wr_break_en;
  logic                   gate_all;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  assign ap_break_en = ctrl_q[`CTL_AP_BREAK];
  assign rd_break_en = ctrl_q[`CTL_RD_BREAK];
  assign wr_break_en = ctrl_q[`CTL_WR_BREAK];
  assign gate_all    = ctrl_q[`CTL_INIT_GATE];

  // ========================================================================
  // Writable registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mask_q <= `RST_MASK;
      ctrl_q <= `RST_CTRL;
    end else if (i_wr) begin
      if (hit(i_addr, `OFS_MASK)) begin
        mask_q <= i_wdata[5:0];
      end
      if (hit(i_addr, `OFS_CTRL)) begin
        ctrl_q <= i_wdata[3:0];
      end
    end
  end

  // ========================================================================
  // Interrupt flags
  // ack ones clear
  assign ack_bits = (i_wr && hit(i_addr, `OFS_ACK)) ? i_wdata[4:0] : 5'h00;

  always_comb begin
    set_bits = 5'h00;
    set_bits[`FLG_OOR_ONE]    = i_oor_valid;
    set_bits[`FLG_OOR_MANY]   = i_oor_valid && flags_q[`FLG_OOR_ONE];
    set_bits[`FLG_INIT_DONE]  = i_init_done;
    set_bits[`FLG_PAGE_CROSS] = i_page_cross;
    set_bits[`FLG_DLL_UNLOCK] = i_dll_unlock;
  end

  // A new event in the same cycle as its ack must not be lost, so set wins.
  assign flags_d = (flags_q[4:0] & ~ack_bits) | set_bits;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flags_q <= 6'h00;
    end else begin
      flags_q <= {|flags_d, flags_d};
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq_q <= 1'b0;
    end else begin
      o_irq_q <= |(flags_q & ~mask_q);
    end
  end

  // ========================================================================
  // Bad-access capture
  // address capture
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bad_q <= '0;
    end else if (i_oor_valid) begin
      bad_q <= i_oor_cmd;
    end
  end

  // ========================================================================
  // Register read port
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata_q <= 32'h0000_0000;
    end else begin
      o_rdata_q <= 32'h0000_0000;
      if (i_rd) begin
        unique case (i_addr)
          `OFS_FLAGS: begin
            o_rdata_q[5:0] <= flags_q;
          end
          `OFS_MASK: begin
            o_rdata_q[5:0] <= mask_q;
          end
          `OFS_CTRL: begin
            o_rdata_q[3:0] <= ctrl_q;
          end
          `OFS_GEOM: begin
            o_rdata_q[`GEO_COL_LSB +: 4] <= `GEO_MAX_COL;
            o_rdata_q[`GEO_ROW_LSB +: 4] <= `GEO_MAX_ROW;
            o_rdata_q[`GEO_CS_LSB +: 2]  <= `GEO_MAX_CS;
          end
          `OFS_BAD_ADDR: begin
            o_rdata_q[30:0] <= bad_q.addr;
          end
          `OFS_BAD_INFO: begin
            o_rdata_q[`INF_LEN_LSB +: 10] <= bad_q.len;
            o_rdata_q[`INF_SRC_LSB +: 3]  <= bad_q.src;
            o_rdata_q[`INF_KIND_LSB +: 2] <= bad_q.kind;
          end
          // The ack register and unmapped offsets read as zero.
          default: begin
            o_rdata_q <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ========================================================================
  // Auto-precharge break decision
  logic same_bank;
  logic new_rd;
  logic new_wr;
  logic ap_open;
  logic brk_other;
  logic brk_read;
  logic brk_write;

  assign same_bank = i_new_cmd.bank == i_open_op.bank;
  assign new_rd    = i_new_cmd.kind == ddr_irq_pkg::cmd_rd;
  assign new_wr    = i_new_cmd.kind == ddr_irq_pkg::cmd_wr;
  assign ap_open   = i_new_cmd.valid && i_open_op.active && i_open_op.autoprecharge;

  assign brk_other = ap_open && !same_bank && ap_break_en;
  assign brk_read  = ap_open && same_bank && !i_open_op.is_write && new_rd && rd_break_en;
  assign brk_write = ap_open && same_bank && i_open_op.is_write && (new_rd || new_wr) &&
                     wr_break_en;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_break_q <= 1'b0;
    end else begin
      o_break_q <= brk_other || brk_read || brk_write;
    end
  end

  // The cut-short bank still owes its precharge; only one can be pending at a time,
  // so the scheduler must retire it before another other-bank break is taken.
  // owed precharge
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_owe_pre_q  <= 1'b0;
      o_owe_bank_q <= 3'h0;
    end else if (brk_other) begin
      o_owe_pre_q  <= 1'b1;
      o_owe_bank_q <= i_open_op.bank;
    end else if (i_owed_pre_done) begin
      o_owe_pre_q  <= 1'b0;
    end
  end

  // ========================================================================
  // DLL-init command gate
  ddr_cmd_gate u_gate (
    .i_clk           (i_clk),
    .i_arst_n        (i_arst_n),
    .i_dll_init_busy (i_dll_init_busy),
    .i_gate_all      (gate_all),
    .i_cmd           (i_new_cmd),
    .o_issue_q       (o_issue_q),
    .o_held_q        (o_held_q)
  );

  // ========================================================================
  // Checks
  property p_irq_out;
    @(posedge i_clk) disable iff (!i_arst_n)
    ##1 (o_irq_q == $past(|(flags_q & ~mask_q)));
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("irq output mismatch");

  property p_flag_top;
    @(posedge i_clk) disable iff (!i_arst_n)
    flags_q[`FLG_ANY] == (|flags_q[4:0]);
  endproperty
  a_flag_top: assert property (p_flag_top) else $error("summary flag wrong");

  property p_oor_one;
    @(posedge i_clk) disable iff (!i_arst_n)
    i_oor_valid |=> flags_q[`FLG_OOR_ONE] && flags_q[`FLG_ANY];
  endproperty
  a_oor_one: assert property (p_oor_one) else $error("single oor flag missing");

  property p_oor_many;
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_oor_valid && flags_q[`FLG_OOR_ONE]) |=> flags_q[`FLG_OOR_MANY];
  endproperty
  a_oor_many: assert property (p_oor_many) else $error("multi oor flag missing");

  property p_init_page;
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_init_done || i_page_cross) |=>
      (flags_q[`FLG_INIT_DONE] || !$past(i_init_done)) &&
      (flags_q[`FLG_PAGE_CROSS] || !$past(i_page_cross));
  endproperty
  a_init_page: assert property (p_init_page) else $error("init/page flag missing");

  property p_dll;
    @(posedge i_clk) disable iff (!i_arst_n)
    i_dll_unlock |=>
      flags_q[`FLG_DLL_UNLOCK] && flags_q[`FLG_ANY];
  endproperty
  a_dll: assert property (p_dll) else $error("dll unlock flag missing");

  property p_ack;
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_wr && i_addr == `OFS_ACK && i_wdata[`FLG_INIT_DONE] && !i_init_done)
      |=> !flags_q[`FLG_INIT_DONE];
  endproperty
  a_ack: assert property (p_ack) else $error("ack did not clear flag");

  property p_ack_read;
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_rd && i_addr == `OFS_ACK) |=> (o_rdata_q == 32'h0000_0000);
  endproperty
  a_ack_read: assert property (p_ack_read) else $error("ack read not zero");

  property p_geom;
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_rd && i_addr == `OFS_GEOM) |=>
      o_rdata_q == {22'h0, `GEO_MAX_CS, `GEO_MAX_ROW, `GEO_MAX_COL};
  endproperty
  a_geom: assert property (p_geom) else $error("geometry read wrong");

  property p_capture;
    @(posedge i_clk) disable iff (!i_arst_n)
    i_oor_valid |=> (bad_q == $past(i_oor_cmd));
  endproperty
  a_capture: assert property (p_capture) else $error("bad access not captured");

  property p_hold;
    @(posedge i_clk) disable iff (!i_arst_n)
    !i_oor_valid |=> $stable(bad_q);
  endproperty
  a_hold: assert property (p_hold) else $error("bad access fields changed");

  property p_no_brk_other;
    @(posedge i_clk) disable iff (!i_arst_n)
    (ap_open && !same_bank && !ap_break_en && !brk_read && !brk_write) |=> !o_break_q;
  endproperty
  a_no_brk_other: assert property (p_no_brk_other) else $error("break while disabled");

  property p_owe;
    @(posedge i_clk) disable iff (!i_arst_n)
    brk_other |=> o_break_q && o_owe_pre_q && (o_owe_bank_q == $past(i_open_op.bank));
  endproperty
  a_owe: assert property (p_owe) else $error("owed precharge lost");

  property p_rd_brk;
    @(posedge i_clk) disable iff (!i_arst_n)
    (ap_open && same_bank && !i_open_op.is_write && new_rd) |=> (o_break_q == $past(rd_break_en));
  endproperty
  a_rd_brk: assert property (p_rd_brk) else $error("read-AP break wrong");

  property p_wr_brk;
    @(posedge i_clk) disable iff (!i_arst_n)
    (ap_open && same_bank && i_open_op.is_write && (new_rd || new_wr))
      |=> (o_break_q == $past(wr_break_en));
  endproperty
  a_wr_brk: assert property (p_wr_brk) else $error("write-AP break wrong");

endmodule : ddr_irq_ctrl

//--- testbench/dram_precharge_model.sv
// Far-side memory model that carries out an owed precharge after a set delay.
`timescale 1ns/1ps
module dram_precharge_model #(
  parameter int LAT = 4
) (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_owe_pre,
  output logic      o_pre_done
);
  // ==========================================================================
  // Precharge responder
  int cnt_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q      <= 0;
      o_pre_done <= 1'b0;
    end else begin
      o_pre_done <= i_owe_pre && !o_pre_done && cnt_q == LAT - 1;
      cnt_q      <= (i_owe_pre && !o_pre_done && cnt_q < LAT - 1) ? cnt_q + 1 : 0;
    end
  end
endmodule : dram_precharge_model

//--- testbench/ddr_irq_ctrl_test.sv
// Self-checking bench for the DDR interrupt, capture and command option block.
`timescale 1ns/1ps
`include "ddr_irq_cfg.svh"
module ddr_irq_ctrl_test;
  // ==========================================================================
  // Signals
  localparam int LAT = 4;
  typedef struct packed {
    logic [3:0] ctrl;
    logic       busy;
    logic       wrt;
    logic       ap;
    logic [2:0] obank;
    logic [2:0] kind;
    logic [2:0] nbank;
    logic [2:0] exp;
  } row_s;

  logic                  i_clk;
  logic                  i_arst_n;
  logic [7:0]            i_addr;
  logic [31:0]           i_wdata;
  logic                  i_wr;
  logic                  i_rd;
  logic [31:0]           o_rdata_q;
  logic [3:0]            ev;
  logic                  busy;
  logic                  owed_done;
  ddr_irq_pkg::bad_cmd_s bad;
  ddr_irq_pkg::open_op_s i_open_op;
  ddr_irq_pkg::new_cmd_s i_new_cmd;
  logic                  o_break_q;
  logic                  o_owe_pre_q;
  logic [2:0]            o_owe_bank_q;
  logic                  o_issue_q;
  logic                  o_held_q;
  logic                  o_irq_q;
  int                    fails;
  int                    cmp_count;
  int                    n;

  // Expected {break, issue, held} for each option and gate setting.
  row_s rows [15] = '{
    '{4'h1, 1'h0, 1'h0, 1'h1, 3'h2, 3'h3, 3'h5, 3'h6},
    '{4'h0, 1'h0, 1'h0, 1'h1, 3'h2, 3'h3, 3'h5, 3'h2},
    '{4'h1, 1'h0, 1'h0, 1'h1, 3'h2, 3'h3, 3'h2, 3'h2},
    '{4'h2, 1'h0, 1'h0, 1'h1, 3'h2, 3'h3, 3'h2, 3'h6},
    '{4'h2, 1'h0, 1'h0, 1'h1, 3'h2, 3'h4, 3'h2, 3'h2},
    '{4'h4, 1'h0, 1'h1, 1'h1, 3'h3, 3'h4, 3'h3, 3'h6},
    '{4'h4, 1'h0, 1'h1, 1'h1, 3'h3, 3'h3, 3'h3, 3'h6},
    '{4'h3, 1'h0, 1'h1, 1'h1, 3'h3, 3'h3, 3'h3, 3'h2},
    '{4'h7, 1'h0, 1'h0, 1'h0, 3'h2, 3'h3, 3'h5, 3'h2},
    '{4'h0, 1'h1, 1'h0, 1'h0, 3'h0, 3'h0, 3'h1, 3'h2},
    '{4'h0, 1'h1, 1'h0, 1'h0, 3'h0, 3'h1, 3'h1, 3'h2},
    '{4'h0, 1'h1, 1'h0, 1'h0, 3'h0, 3'h2, 3'h1, 3'h1},
    '{4'h0, 1'h1, 1'h0, 1'h0, 3'h0, 3'h5, 3'h1, 3'h1},
    '{4'h8, 1'h1, 1'h0, 1'h0, 3'h0, 3'h0, 3'h1, 3'h1},
    '{4'h8, 1'h0, 1'h0, 1'h0, 3'h0, 3'h2, 3'h1, 3'h2}
  };

  // ==========================================================================
  // Design and far side
  ddr_irq_ctrl u_dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata_q(o_rdata_q), .i_oor_valid(ev[0]),
    .i_oor_cmd(bad), .i_init_done(ev[1]), .i_page_cross(ev[2]),
    .i_dll_unlock(ev[3]), .i_dll_init_busy(busy), .i_open_op(i_open_op),
    .i_new_cmd(i_new_cmd), .i_owed_pre_done(owed_done), .o_break_q(o_break_q),
    .o_owe_pre_q(o_owe_pre_q), .o_owe_bank_q(o_owe_bank_q), .o_issue_q(o_issue_q),
    .o_held_q(o_held_q), .o_irq_q(o_irq_q)
  );

  dram_precharge_model #(.LAT(LAT)) u_mem (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_owe_pre(o_owe_pre_q), .o_pre_done(owed_done)
  );

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 chk(o_rdata_q, e);
  endtask : rd

  task automatic pulse(input logic [3:0] m);
    @(posedge i_clk);
    ev <= m;
    @(posedge i_clk);
    ev <= 4'h0;
  endtask : pulse

  task automatic irq(input logic e);
    repeat (2) @(posedge i_clk);
    #1 chk({31'h0, o_irq_q}, {31'h0, e});
  endtask : irq

  task automatic cap(input ddr_irq_pkg::bad_cmd_s b);
    rd(`OFS_BAD_ADDR, {1'b0, b.addr});
    rd(`OFS_BAD_INFO, {10'h0, b.kind, 1'b0, b.src, 6'h0, b.len});
  endtask : cap

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Clock, watchdog and test sequence
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // The whole sequence needs well under 1000 cycles.
  initial begin
    #100000;
    fails++;
    stop_test();
  end

  initial begin
    {i_arst_n, i_addr, i_wdata, i_wr, i_rd, ev, busy} = '0;
    {bad, i_open_op, i_new_cmd} = '0;
    fails = 0;
    cmp_count = 0;
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    foreach (rows[k]) begin
      wr(`OFS_CTRL, {28'h0, rows[k].ctrl});
      @(posedge i_clk);
      i_open_op <= '{1'b1, rows[k].wrt, rows[k].ap, rows[k].obank};
      i_new_cmd <= '{1'b1, ddr_irq_pkg::cmd_kind_e'(rows[k].kind), rows[k].nbank};
      busy      <= rows[k].busy;
      @(posedge i_clk);
      #1 chk({o_break_q, o_issue_q, o_held_q}, rows[k].exp);
    end
    $display("test option rows done");
    rd(`OFS_FLAGS, 32'h0);
    rd(`OFS_GEOM, {22'h0, `GEO_MAX_CS, `GEO_MAX_ROW, `GEO_MAX_COL});
    rd(`OFS_ACK, 32'h0);
    rd(8'h1c, 32'h0);
    wr(`OFS_GEOM, 32'h0);
    rd(`OFS_GEOM, {22'h0, `GEO_MAX_CS, `GEO_MAX_ROW, `GEO_MAX_COL});
    wr(`OFS_CTRL, 32'hf);
    rd(`OFS_CTRL, 32'hf);
    $display("test registers done");
    wr(`OFS_MASK, 32'h3f);
    bad <= '{31'h5a5a1234, 10'h3ff, 3'h5, 2'h2};
    pulse(4'h1);
    rd(`OFS_FLAGS, 32'h21);
    irq(1'b0);
    cap(bad);
    wr(`OFS_MASK, 32'h0);
    irq(1'b1);
    bad <= '{31'h01234567, 10'h001, 3'h2, 2'h1};
    pulse(4'h1);
    rd(`OFS_FLAGS, 32'h23);
    pulse(4'he);
    rd(`OFS_FLAGS, 32'h3f);
    cap(bad);
    $display("test events done");
    wr(`OFS_ACK, 32'h0);
    wr(`OFS_FLAGS, 32'h0);
    rd(`OFS_FLAGS, 32'h3f);
    wr(`OFS_ACK, 32'h1);
    rd(`OFS_FLAGS, 32'h3e);
    wr(`OFS_MASK, 32'h2f);
    rd(`OFS_MASK, 32'h2f);
    irq(1'b1);
    wr(`OFS_ACK, 32'h10);
    rd(`OFS_FLAGS, 32'h2e);
    irq(1'b0);
    wr(`OFS_ACK, 32'h1f);
    rd(`OFS_FLAGS, 32'h0);
    $display("test acknowledge done");
    wr(`OFS_CTRL, 32'h1);
    busy <= 1'b0;
    for (n = 0; n < 20 && o_owe_pre_q !== 1'b0; n++) @(posedge i_clk);
    @(posedge i_clk);
    i_open_op <= '{1'b1, 1'b0, 1'b1, 3'h2};
    i_new_cmd <= '{1'b1, ddr_irq_pkg::cmd_rd, 3'h5};
    @(posedge i_clk);
    i_new_cmd <= '0;
    #1 chk({o_break_q, o_owe_pre_q, o_owe_bank_q}, 5'h1a);
    n = 0;
    while (o_owe_pre_q === 1'b1 && n < 30) begin
      @(posedge i_clk);
      #1 n++;
    end
    chk({31'h0, n >= LAT && n <= LAT + 2}, 32'h1);
    $display("test owed precharge done");
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd(`OFS_MASK, 32'h0);
    rd(`OFS_CTRL, 32'h0);
    rd(`OFS_BAD_ADDR, 32'h0);
    $display("test second reset done");
    stop_test();
  end
endmodule : ddr_irq_ctrl_test
